// file: bench/emac_frame_fifo_properties.sv
/* port-level checker for the mac frame block.
   assumes it is bound onto emac_frame_fifo, one clock domain. */
`timescale 1ns/1ps
`default_nettype none
`include "emac_consts.svh"
module emac_frame_fifo_properties (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // apb
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic        pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    // mii transmit
    input wire logic        mii_tx_en_o,
    input wire logic [3:0]  mii_txd_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // decoded offsets
    wire mapped_w = paddr_i inside {`ADDR_RAW_IRQ, `ADDR_RX_CONTROL, `ADDR_TX_CONTROL,
        `ADDR_DATA, `ADDR_STA_LOW, `ADDR_STA_HIGH, `ADDR_STATUS};
    // transmit burst length
    logic [11:0] run_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) run_q <= 12'h000;
        else run_q <= mii_tx_en_o ? run_q + 12'h001 : 12'h000;
    end
    ////////////////////////////////////////////////////////////////////////
    setup_gets_ack_a: assert property (
        psel_i && !penable_i |=> pready_o) else $error("no ready after setup");
    ack_has_cause_a: assert property (
        pready_o |-> $past(psel_i && !penable_i) ##1 !pready_o) else $error("stray ready");
    rdata_idle_a: assert property (
        !pready_o |-> prdata_o == 32'h0000_0000) else $error("read data outside access");
    err_decode_a: assert property (
        pready_o |-> pslverr_o == !$past(mapped_w)) else $error("error response wrong");
    txd_idle_a: assert property (
        !mii_tx_en_o |-> mii_txd_o == 4'h0) else $error("data while not sending");
    preamble_sfd_a: assert property (
        $rose(mii_tx_en_o) |-> (mii_txd_o == `NIB_PREAMBLE)[*8] ##1
        (mii_txd_o == `NIB_PREAMBLE)[*7] ##1 mii_txd_o == `NIB_SFD)
        else $error("bad preamble or delimiter");
    gap_after_a: assert property (
        $fell(mii_tx_en_o) |-> (!mii_tx_en_o)[*8] ##1 (!mii_tx_en_o)[*8] ##1 (!mii_tx_en_o)[*8])
        else $error("gap too short");
    frame_min_a: assert property (
        $fell(mii_tx_en_o) |-> run_q >= 12'd52) else $error("frame too short");
endmodule : emac_frame_fifo_properties
bind emac_frame_fifo emac_frame_fifo_properties props (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .mii_tx_en_o(mii_tx_en_o),
    .mii_txd_o(mii_txd_o));
`default_nettype wire

// file: bench/emac_frame_fifo_tb.sv
/* self-checking bench: apb register and buffer traffic, mii loopback.
   assumes phy_model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
`include "emac_consts.svh"
module emac_frame_fifo_tb;
    logic        clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err_s;
    logic        mii_tx_en_o, mii_rx_dv_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd, crc, v;
    logic [3:0]  mii_txd_o, mii_rxd_i;
    logic [7:0]  da [6];
    logic [7:0]  fb [$];
    int          n_errors = 0, cmp_count = 0, seed = 32'h3d90_99bc, plen;
    emac_frame_fifo #(.DEPTH_WORDS(64)) dut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
        .mii_tx_en_o(mii_tx_en_o), .mii_txd_o(mii_txd_o), .mii_rx_dv_i(mii_rx_dv_i),
        .mii_rxd_i(mii_rxd_i));
    phy_model phy (.clk_i(clk_i), .mii_tx_en_i(mii_tx_en_o), .mii_txd_i(mii_txd_o),
        .mii_rx_dv_o(mii_rx_dv_i), .mii_rxd_o(mii_rxd_i));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    // reference crc per octet
    function automatic logic [31:0] crc8(logic [31:0] c, logic [7:0] b);
        c = c ^ {24'h00_0000, b};
        for (int i = 0; i < 8; i++) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
        return c;
    endfunction : crc8
    // buffer word k of the octet stream
    function automatic logic [31:0] wd(int k);
        for (int j = 0; j < 4; j++) wd[8*j +: 8] = (4*k-2+j < fb.size()) ? fb[4*k-2+j] : 8'h00;
    endfunction : wd
    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    // one apb transfer after an idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_errors++;
            print_verdict();
        end
        rd = prdata_o;
        err_s = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0000_0000;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        apb(1'b0, `ADDR_TX_CONTROL, 32'h0000_0000);
        chk(rd, 32'h0000_0006);
        apb(1'b0, `ADDR_RX_CONTROL, 32'h0000_0000);
        chk(rd, 32'h0000_0008);
        apb(1'b0, 12'h00c, 32'h0000_0000);
        chk({rd[31:1], err_s}, 32'h0000_0001);
        // expected octets: random payload, pad, crc
        plen = 1 + ($unsigned($random(seed)) % 20);
        for (int i = 0; i < 6; i++) da[i] = 8'($random(seed));
        da[0][0] = 1'b0; // individual address
        for (int i = 0; i < 6; i++) fb.push_back(da[i]);
        for (int i = 0; i < 6; i++) fb.push_back(8'($random(seed)));
        fb.push_back(8'h00);
        fb.push_back(8'(plen)); // length value, high octet first
        for (int i = 0; i < plen; i++) fb.push_back(8'($random(seed)));
        while (fb.size() < 60) fb.push_back(8'h00);
        crc = `CRC_INIT;
        foreach (fb[i]) crc = crc8(crc, fb[i]);
        crc = ~crc;
        for (int k = 0; k < 4; k++) fb.push_back(crc[8*k +: 8]);
        // load with transmitter off: nothing may leave
        apb(1'b1, `ADDR_DATA, {fb[1], fb[0], 16'(plen)});
        for (int k = 1; k < (19 + plen) / 4; k++) apb(1'b1, `ADDR_DATA, wd(k));
        repeat (40) @(posedge clk_i);
        chk(phy.cap.size(), 0);
        apb(1'b1, `ADDR_TX_CONTROL, 32'h0000_0017);
        for (int n = 0; phy.cap.size() < 16 + 2 * fb.size() || mii_tx_en_o; n++) begin
            if (n > 3000) begin
                n_errors++;
                print_verdict();
            end
            @(posedge clk_i);
        end
        chk(phy.cap.size(), 16 + 2 * fb.size());
        for (int i = 0; i < phy.cap.size(); i++) begin
            v = i < 15 ? 32'h0000_0005 : i == 15 ? 32'h0000_000d :
                32'(fb[(i-16)/2] >> (4 * (i % 2))) & 32'h0000_000f;
            chk({28'h000_0000, phy.cap[i]}, v);
        end
        // loop back, station address matching
        apb(1'b1, `ADDR_STA_LOW, {da[3], da[2], da[1], da[0]});
        apb(1'b1, `ADDR_STA_HIGH, {16'h0000, da[5], da[4]});
        apb(1'b1, `ADDR_RX_CONTROL, 32'h0000_0009);
        phy.send(-1);
        repeat (phy.cap.size() + 6) @(posedge clk_i);
        apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
        chk(32'(rd[12:8]), 32'h0000_0001);
        apb(1'b0, `ADDR_DATA, 32'h0000_0000);
        chk(rd, {fb[1], fb[0], 16'(fb.size())});
        for (int k = 1; k < (fb.size() + 5) / 4; k++) begin
            apb(1'b0, `ADDR_DATA, 32'h0000_0000);
            chk(rd, wd(k));
        end
        apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
        chk(32'(rd[12:8]), 32'h0000_0000);
        // corrupt a payload nibble: frame dropped
        phy.send(50);
        repeat (phy.cap.size() + 6) @(posedge clk_i);
        apb(1'b0, `ADDR_STATUS, 32'h0000_0000);
        chk(32'(rd[12:8]), 32'h0000_0000);
        print_verdict();
    end
endmodule : emac_frame_fifo_tb
`default_nettype wire

// file: bench/phy_model.sv
/* phy partner on the mii: records sent nibbles and can replay them back.
   assumes one nibble per clk_i in both directions. */
`timescale 1ns/1ps
`default_nettype none
module phy_model (
    // mii from the mac
    input  wire logic       clk_i,
    input  wire logic       mii_tx_en_i,
    input  wire logic [3:0] mii_txd_i,
    // mii towards the mac
    output var logic        mii_rx_dv_o,
    output var logic [3:0]  mii_rxd_o
);
    logic [3:0] cap [$];
    int         pos  = -1;
    int         flip = -1;
    initial mii_rx_dv_o = 1'b0;
    initial mii_rxd_o = 4'h0;
    // record line order, low nibble of each octet first
    always @(posedge clk_i) if (mii_tx_en_i) cap.push_back(mii_txd_i);
    // replay; idle data toggles
    always @(posedge clk_i) begin
        if (pos >= 0 && pos < cap.size()) begin
            mii_rx_dv_o <= 1'b1;
            mii_rxd_o   <= cap[pos] ^ {3'b000, pos == flip};
            pos         <= pos + 1;
        end else begin
            mii_rx_dv_o <= 1'b0;
            mii_rxd_o   <= ~mii_rxd_o;
            if (pos >= 0) pos <= -1;
        end
    end
    // replay from next edge; nibble f corrupted
    task automatic send(input int f);
        @(posedge clk_i);
        flip <= f;
        pos  <= 0;
    endtask : send
endmodule : phy_model
`default_nettype wire

// file: verilog/emac_consts.svh
/*
 * register offsets, field positions, reset values and frame constants
 * of the ethernet mac framing and buffering block.
 * assumes a 32-bit apb slave with word aligned registers.
 */
// Notes on behaviour
// - fields go preamble to fcs; each octet leaves low bit first.
// - every transmitted frame opens with seven preamble octets.
// - a start-of-frame octet 1010.1011 follows the preamble directly.
// - first bit of destination address marks group (1) or individual (0).
// - length/type up to 1500 counts payload octets; above that it is type.
// - length/type goes out most significant octet first.
// - with pad enable, payload under 46 octets is padded up to 46.
// - no too-long error; overrun flagged only when receive storage overflows; the code also flags it when a frame starts with the count at 31.
// - fcs is crc-32 over addresses, length/type and data including pad.
// - crc advances one nibble per step.
// - fcs insert set appends generated fcs; cleared sends frame without it.
// - every received fcs is checked; reject set drops failing frames.
// - transmit and receive overlap only while duplex is set.
// - transmit buffer is 2 KB, one frame, 16 header bytes first.
// - receive buffer is 2 KB and holds at most 31 frames; the code still stores a 32nd frame and its count wraps to 0.
// - frame arriving without room sets the receive overrun flag.
// - first word: length low, length high, destination octets one and two.
// - transmit length counts payload; receive length counts whole frame.
// - words two to four hold header rest; payload from fifth word.
// - fcs may sit unaligned; each received frame starts on a word.
// - nothing is transmitted unless transmitter enable is set.
// - flush empties the receive buffer after receiver is disabled.
// - station address match, widened by promiscuous and all-multicast bits.
`ifndef EMAC_CONSTS_SVH
`define EMAC_CONSTS_SVH
`define ADDR_RAW_IRQ      12'h000
`define ADDR_RX_CONTROL   12'h004
`define ADDR_TX_CONTROL   12'h008
`define ADDR_DATA         12'h010
`define ADDR_STA_LOW      12'h014
`define ADDR_STA_HIGH     12'h018
`define ADDR_STATUS       12'h01C
`define BIT_RX_OVERRUN    0
`define BIT_RECEIVER_ENABLE          0
`define BIT_ALL_MULTICAST_ENABLE          1
`define BIT_PROMISCUOUS_ENABLE          2
`define BIT_REJECT        3
`define BIT_FLUSH         4
`define BIT_TRANSMITTER_ENABLE          0
`define BIT_PAD_ENABLE         1
`define BIT_FCSINS        2
`define BIT_DUPLEX        4
`define RX_CONTROL_RESET  5'h08
`define TX_CONTROL_RESET  5'h06
`define BYTE_PREAMBLE     8'h55
`define BYTE_SFD          8'hD5
`define NIB_PREAMBLE      4'h5
`define NIB_SFD           4'hD
`define PREAMBLE_OCTETS   4'd7
`define HEADER_BYTES      13'd16
`define MIN_PAYLOAD       13'd46
`define GAP_NIBBLES       5'd24
`define MAX_RX_FRAMES     5'd31
`define CRC_INIT          32'hFFFF_FFFF
`define CRC_POLY          32'hEDB8_8320
`define CRC_RESIDUE       32'hDEBB_20E3
`endif

// file: verilog/emac_frame_fifo.sv
/*
 * ethernet mac framing with one-frame transmit buffer and multi-frame
 * receive buffer, apb register slave and nibble wide mii towards the phy.
 * assumes the mii nibbles are synchronous to clk_i, one nibble per clock.
 */
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "emac_consts.svh"
module emac_frame_fifo
    import emac_pkg::*;
#(
    parameter int DEPTH_WORDS = 512
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    // mii transmit
    output logic             mii_tx_en_o,
    output logic [3:0]       mii_txd_o,
    // mii receive
    input  wire logic        mii_rx_dv_i,
    input  wire logic [3:0]  mii_rxd_i
);
    localparam int AW = $clog2(DEPTH_WORDS);
    initial begin
        if (DEPTH_WORDS < 16 || DEPTH_WORDS > 2048 || (1 << AW) != DEPTH_WORDS)
            $error("DEPTH_WORDS must be a power of two from 16 to 2048");
    end

    // one crc-32 step over a nibble, low bit first
    function automatic logic [31:0] crc_nib(input logic [31:0] c, input logic [3:0] n);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 4; i++) begin
            r = (r[0] ^ n[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_nib

    ////////////////////////////////////////////////////////////////////
    // registers and apb decode
    logic [4:0]  rx_ctl;
    logic [4:0]  tx_ctl;
    logic [31:0] sta_low;
    logic [15:0] sta_high;
    logic        rx_overrun_flag;
    logic [31:0] tx_mem [DEPTH_WORDS];
    logic [31:0] rx_mem [DEPTH_WORDS];
    logic [AW:0] tx_wptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] rx_used;
    logic [4:0]  rx_frames;
    logic [AW-1:0] rd_left;
    logic        rd_in_frame;
    tx_state_t   tx_state;
    rx_state_t   rx_state;

    wire setup      = psel_i & ~penable_i;
    wire access     = psel_i & penable_i & pready_o;
    wire wr_acc     = access & pwrite_i;
    wire rd_acc     = access & ~pwrite_i;
    wire hit_data   = paddr_i == `ADDR_DATA;
    wire mapped     = paddr_i == `ADDR_RAW_IRQ || paddr_i == `ADDR_RX_CONTROL
                    || paddr_i == `ADDR_TX_CONTROL || hit_data
                    || paddr_i == `ADDR_STA_LOW || paddr_i == `ADDR_STA_HIGH
                    || paddr_i == `ADDR_STATUS;
    wire tx_busy    = tx_state != T_IDLE;
    wire rx_busy    = rx_state != R_IDLE;
    wire rx_avail   = rx_frames != 5'd0;
    // pushes land only while no frame is being sent and room remains
    wire tx_push    = wr_acc & hit_data & ~tx_busy & ~tx_wptr[AW];
    wire rx_pop     = rd_acc & hit_data & rx_avail;
    wire flush      = wr_acc & (paddr_i == `ADDR_RX_CONTROL)
                    & pwdata_i[`BIT_FLUSH] & ~rx_ctl[`BIT_RECEIVER_ENABLE];
    wire [31:0] status_word = {16'h0000, 3'b000, rx_frames, 7'h00, tx_busy};
    wire [31:0] rd_word =
        paddr_i == `ADDR_RAW_IRQ    ? {31'h0000_0000, rx_overrun_flag} :
        paddr_i == `ADDR_RX_CONTROL ? {27'h000_0000, rx_ctl} :
        paddr_i == `ADDR_TX_CONTROL ? {27'h000_0000, tx_ctl} :
        paddr_i == `ADDR_DATA       ? (rx_avail ? rx_mem[rd_ptr] : 32'h0000_0000) :
        paddr_i == `ADDR_STA_LOW    ? sta_low :
        paddr_i == `ADDR_STA_HIGH   ? {16'h0000, sta_high} :
        paddr_i == `ADDR_STATUS     ? status_word : 32'h0000_0000;

    // answer one cycle after setup: pready high in the first access cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup;
            prdata_o  <= setup && !pwrite_i ? rd_word : 32'h0000_0000;
            pslverr_o <= setup & ~mapped;
        end
    end

    // control registers; the flush bit is a strobe and never stored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_ctl   <= `RX_CONTROL_RESET;
            tx_ctl   <= `TX_CONTROL_RESET;
            sta_low  <= 32'h0000_0000;
            sta_high <= 16'h0000;
        end else if (wr_acc) begin
            if (paddr_i == `ADDR_RX_CONTROL) rx_ctl <= {1'b0, pwdata_i[3:0]};
            if (paddr_i == `ADDR_TX_CONTROL) tx_ctl <= {pwdata_i[4], 1'b0, pwdata_i[2:0]};
            if (paddr_i == `ADDR_STA_LOW) sta_low <= pwdata_i;
            if (paddr_i == `ADDR_STA_HIGH) sta_high <= pwdata_i[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // transmit buffer and serializer
    logic [12:0] bc;          // byte address inside the buffer
    logic [4:0]  cnt;
    logic        hi;          // second nibble of the current byte
    logic [31:0] tx_crc;
    wire  [12:0] tx_len  = {1'b0, tx_mem[0][11:0]};
    wire         crc_ins = tx_ctl[`BIT_FCSINS];
    // shortest data field: 46 octets when padding, else the given length
    wire  [12:0] data_len = (tx_ctl[`BIT_PAD_ENABLE] && tx_len < `MIN_PAYLOAD)
                          ? `MIN_PAYLOAD : tx_len;
    wire  [12:0] body_end = `HEADER_BYTES + data_len;
    wire  [12:0] need_b   = `HEADER_BYTES + tx_len + (crc_ins ? 13'd0 : 13'd4) + 13'd3;
    wire  [AW:0] need_w   = need_b[AW+2:2];
    wire         loaded   = tx_wptr != '0 && tx_wptr >= need_w;
    wire         tx_go    = loaded & tx_ctl[`BIT_TRANSMITTER_ENABLE]
                          & (tx_ctl[`BIT_DUPLEX] | ~rx_busy & ~mii_rx_dv_i);
    // software fcs sits right after the unpadded payload
    wire  [12:0] mem_b    = tx_state == T_FCS
                          ? `HEADER_BYTES + tx_len + {8'h00, cnt} : bc;
    wire  [31:0] mem_w    = tx_mem[mem_b[AW+1:2]];
    wire  [7:0]  mem_byte = mem_w[{mem_b[1:0], 3'b000} +: 8];
    wire  [31:0] fcs_w    = ~tx_crc;
    wire  [7:0]  tx_byte  =
        tx_state == T_PRE  ? `BYTE_PREAMBLE :
        tx_state == T_SFD  ? `BYTE_SFD :
        tx_state == T_FCS  ? (crc_ins ? fcs_w[{cnt[1:0], 3'b000} +: 8] : mem_byte) :
        bc < `HEADER_BYTES + tx_len ? mem_byte : 8'h00;
    wire  [3:0]  tx_nib   = hi ? tx_byte[7:4] : tx_byte[3:0];

    always_ff @(posedge clk_i) begin
        if (tx_push) tx_mem[tx_wptr[AW-1:0]] <= pwdata_i;
    end

    // frame sequencer, one nibble per clock; the buffer is freed after the gap
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_state    <= T_IDLE;
            tx_wptr     <= '0;
            bc          <= 13'd0;
            cnt         <= 5'd0;
            hi          <= 1'b0;
            tx_crc      <= `CRC_INIT;
            mii_tx_en_o <= 1'b0;
            mii_txd_o   <= 4'h0;
        end else begin
            mii_tx_en_o <= tx_state inside {T_PRE, T_SFD, T_BODY, T_FCS};
            mii_txd_o   <= tx_state == T_IDLE || tx_state == T_GAP ? 4'h0 : tx_nib;
            if (tx_push) tx_wptr <= tx_wptr + 1'b1;
            if (tx_state != T_IDLE && tx_state != T_GAP) hi <= ~hi;
            unique case (tx_state)
                T_IDLE: if (tx_go) begin
                    tx_state <= T_PRE;
                    cnt      <= 5'd0;
                    hi       <= 1'b0;
                    tx_crc   <= `CRC_INIT;
                end
                T_PRE: if (hi) begin
                    cnt <= cnt + 5'd1;
                    if (cnt == {1'b0, `PREAMBLE_OCTETS} - 5'd1) tx_state <= T_SFD;
                end
                T_SFD: if (hi) begin
                    tx_state <= T_BODY;
                    bc       <= 13'd2; // destination octet one first
                end
                T_BODY: begin
                    tx_crc <= crc_nib(tx_crc, tx_nib);
                    if (hi) begin
                        bc <= bc + 13'd1;
                        if (bc == body_end - 13'd1) begin
                            tx_state <= T_FCS;
                            cnt      <= 5'd0;
                        end
                    end
                end
                T_FCS: if (hi) begin
                    cnt <= cnt + 5'd1;
                    if (cnt == 5'd3) begin
                        tx_state <= T_GAP;
                        cnt      <= 5'd0;
                    end
                end
                T_GAP: begin
                    cnt <= cnt + 5'd1;
                    if (cnt == `GAP_NIBBLES - 5'd1) begin
                        tx_state <= T_IDLE;
                        tx_wptr  <= '0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive deserializer, filter and buffer
    logic [AW-1:0] fr_start;
    logic [12:0]   k;          // octets received after the start delimiter
    logic          rhi;
    logic [3:0]    rlo;
    logic [31:0]   rx_crc;
    logic [31:0]   wbuf;
    logic [7:0]    da1;
    logic [7:0]    da2;
    logic [39:0]   da_rest;
    wire  [7:0]    rx_byte  = {mii_rxd_i, rlo};
    wire  [12:0]   pos      = k + 13'd2;
    wire  [AW:0]   fr_words = {1'b0, pos[AW+1:2]} + 1'b1;
    wire  [AW:0]   free_w   = DEPTH_WORDS[AW:0] - rx_used;
    // the word being closed and any later one must still fit
    wire           room     = fr_words < free_w;
    wire  [47:0]   da_line  = {rx_byte, da_rest[39:16], da2, da1};
    wire  [47:0]   sta_line = {sta_high, sta_low};
    wire           addr_ok  = rx_ctl[`BIT_PROMISCUOUS_ENABLE] || da_line == sta_line
                            || (rx_ctl[`BIT_ALL_MULTICAST_ENABLE] && da1[0]);
    wire           fcs_bad  = rx_crc != `CRC_RESIDUE;
    wire           rx_may   = rx_ctl[`BIT_RECEIVER_ENABLE] & (tx_ctl[`BIT_DUPLEX] | ~tx_busy);
    wire  [AW-1:0] wr_addr  = rx_state == R_HDR ? fr_start : fr_start + pos[AW+1:2];
    wire           wr_en    = (rx_state == R_DATA && mii_rx_dv_i && rhi && k >= 13'd2
                              && pos[1:0] == 2'd3) || rx_state == R_FLUSH
                              || rx_state == R_HDR;
    wire  [31:0]   wr_word  = rx_state == R_HDR ? {da2, da1, 3'b000, k}
                            : rx_state == R_FLUSH ? wbuf
                            : {rx_byte, wbuf[23:0]};

    always_ff @(posedge clk_i) begin
        if (wr_en) rx_mem[wr_addr] <= wr_word;
    end

    // receive sequencer: hunt, collect, close word, write header
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_state <= R_IDLE;
            fr_start <= '0;
            k        <= 13'd0;
            rhi      <= 1'b0;
            rlo      <= 4'h0;
            rx_crc   <= `CRC_INIT;
            wbuf     <= 32'h0000_0000;
            da1      <= 8'h00;
            da2      <= 8'h00;
            da_rest  <= 40'h00_0000_0000;
        end else if (flush) begin
            rx_state <= R_IDLE;
            fr_start <= '0;
        end else begin
            unique case (rx_state)
                R_IDLE: if (mii_rx_dv_i) rx_state <= rx_may ? R_PRE : R_DROP;
                R_PRE: begin
                    k      <= 13'd0;
                    rhi    <= 1'b0;
                    rx_crc <= `CRC_INIT;
                    wbuf   <= 32'h0000_0000;
                    if (!mii_rx_dv_i) rx_state <= R_IDLE;
                    else if (mii_rxd_i == `NIB_SFD) rx_state <= R_DATA;
                    else if (mii_rxd_i != `NIB_PREAMBLE) rx_state <= R_DROP;
                end
                R_DATA: if (!mii_rx_dv_i) begin
                    // a trailing odd nibble is dropped with the frame end
                    if (k < 13'd6 || (rx_ctl[`BIT_REJECT] && fcs_bad)) rx_state <= R_IDLE;
                    else rx_state <= pos[1:0] != 2'd0 ? R_FLUSH : R_HDR;
                end else begin
                    rx_crc <= crc_nib(rx_crc, mii_rxd_i);
                    rhi    <= ~rhi;
                    rlo    <= mii_rxd_i;
                    if (rhi) begin
                        k <= k + 13'd1;
                        if (k == 13'd0) da1 <= rx_byte;
                        if (k == 13'd1) da2 <= rx_byte;
                        if (k >= 13'd2 && k < 13'd6) da_rest <= {rx_byte, da_rest[39:8]};
                        if (k >= 13'd2) wbuf[{pos[1:0], 3'b000} +: 8] <= rx_byte;
                        if (pos[1:0] == 2'd3) wbuf <= 32'h0000_0000;
                        if (k == 13'd5 && !addr_ok) rx_state <= R_DROP;
                        if (!room) rx_state <= R_DROP;
                    end
                end
                R_FLUSH: rx_state <= R_HDR;
                R_HDR: begin
                    rx_state <= R_IDLE;
                    fr_start <= fr_start + fr_words[AW-1:0]
                              - (pos[1:0] == 2'd0 ? 1'b1 : 1'b0);
                end
                R_DROP: if (!mii_rx_dv_i) rx_state <= R_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // occupancy, frame count, read side and overrun flag
    wire commit   = rx_state == R_HDR;
    wire [AW:0] commit_w = fr_words - (pos[1:0] == 2'd0 ? 1'b1 : 1'b0);
    wire frame_in = commit & ~flush;
    wire last_pop = rx_pop & rd_in_frame & rd_left == '0;
    wire [12:0] hdr_pos = rx_mem[rd_ptr][12:0] + 13'd1;
    // too little room, or the frame count already at its limit
    wire ovr_evt  = (rx_state == R_DATA && mii_rx_dv_i && rhi && !room)
                  || (rx_state == R_IDLE && mii_rx_dv_i && rx_may
                      && rx_frames == `MAX_RX_FRAMES);
    wire ovr_clr  = wr_acc & (paddr_i == `ADDR_RAW_IRQ) & pwdata_i[`BIT_RX_OVERRUN];

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ptr      <= '0;
            rx_used     <= '0;
            rx_frames   <= 5'd0;
            rd_left     <= '0;
            rd_in_frame <= 1'b0;
        end else if (flush) begin
            rd_ptr      <= '0;
            rx_used     <= '0;
            rx_frames   <= 5'd0;
            rd_in_frame <= 1'b0;
        end else begin
            rx_used   <= rx_used + (frame_in ? commit_w : '0) - {{AW{1'b0}}, rx_pop};
            rx_frames <= rx_frames + {4'h0, frame_in} - {4'h0, last_pop};
            if (rx_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
                if (!rd_in_frame) begin
                    // header gives octet count; the frame spans that plus two lanes
                    rd_left     <= hdr_pos[AW+1:2] - 1'b1;
                    rd_in_frame <= hdr_pos[AW+1:2] != '0;
                end else begin
                    rd_left     <= rd_left - 1'b1;
                    rd_in_frame <= rd_left != '0;
                end
            end
        end
    end

    // a new overrun beats a clear written in the same cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) rx_overrun_flag <= 1'b0;
        else if (ovr_evt) rx_overrun_flag <= 1'b1;
        else if (ovr_clr) rx_overrun_flag <= 1'b0;
    end

    // frames refused by the filter simply fall away; at the frame limit the frame is still taken and only the overrun flag is set
    wire unused_ok = ^{rx_ctl[4], tx_ctl[3]};

endmodule : emac_frame_fifo
`default_nettype wire

// file: verilog/emac_pkg.sv
/*
 * types shared by the ethernet mac framing block.
 * assumes nothing beyond a systemverilog compiler.
 */
package emac_pkg;
    typedef enum logic [2:0] {T_IDLE, T_PRE, T_SFD, T_BODY, T_FCS, T_GAP} tx_state_t;
    typedef enum logic [2:0] {R_IDLE, R_PRE, R_DATA, R_FLUSH, R_HDR, R_DROP} rx_state_t;
endpackage : emac_pkg
